// ---- shared/adhp_pkg.sv ----
// Package of constants and carrier types for the converter host port.
package adhp_pkg;

    // ==================================================================
    // Port offsets for the default base, and the alternate base shift.
    localparam logic [7:0] ADHP_OFS_CHANNEL_SELECT = 8'hA0;
    localparam logic [7:0] ADHP_OFS_START_RESULT   = 8'hA1;
    localparam logic [7:0] ADHP_OFS_DAC_VALUE      = 8'hA2;
    localparam logic [7:0] ADHP_OFS_IRQ_STATUS     = 8'hA3;
    localparam logic [7:0] ADHP_ALT_BASE_SHIFT     = 8'h04;
    localparam logic [7:0] ADHP_PORT_MASK          = 8'hFC;
    localparam logic [1:0] ADHP_IDX_CHANNEL        = 2'h0;
    localparam logic [1:0] ADHP_IDX_START_RESULT   = 2'h1;
    localparam logic [1:0] ADHP_IDX_DAC            = 2'h2;
    localparam logic [1:0] ADHP_IDX_IRQ_STATUS     = 2'h3;

    // ==================================================================
    // Field positions and reset values.
    localparam int         ADHP_CHANNEL_MSB        = 2;
    localparam int         ADHP_STATUS_DONE_BIT    = 0;
    localparam logic [2:0] ADHP_CHANNEL_RESET      = 3'h0;
    localparam logic [7:0] ADHP_DAC_RESET          = 8'h00;
    localparam logic [7:0] ADHP_RESULT_RESET       = 8'h00;

    // ==================================================================
    // Conversion timing in clock edges.
    localparam logic [3:0] ADHP_CONV_END_EDGES     = 4'h8;

    // ==================================================================
    // Carrier types.
    typedef struct packed {
        logic       default_base;
        logic       alternate_base;
        logic       result_format;
        logic       route_slot;
        logic       route_one;
        logic       route_two;
    } adhp_jumpers_t;

    typedef struct packed {
        logic       slot;
        logic       one;
        logic       two;
    } adhp_irq_lines_t;

    typedef struct packed {
        logic       start;
        logic       running;
        logic       done_n;
        logic [3:0] edge_cnt;
        logic [7:0] result;
    } adhp_conv_state_t;

    typedef struct packed {
        logic [2:0] channel;
        logic [7:0] dac_value;
        logic [7:0] rd_data;
        logic       rd_prev;
        logic       wr_prev;
        logic       busy;
        logic       done_n_prev;
        logic       host_irq;
        logic       cmp_irq;
    } adhp_port_state_t;

endpackage

// ---- rtl/adhp_conv_core.sv ----
// Conversion sequencer: start line, active-low done and result capture.
`timescale 1ns/10ps

module adhp_conv_core (
    // Clock and reset.
    input  wire logic       clk_sys_i,
    input  wire logic       reset_n_i,
    // Request from the port logic.
    input  wire logic       start_req_i,
    input  wire logic       offset_binary_i,
    // Raw sample from the analog front end, two's complement when bipolar.
    input  wire logic [7:0] sample_i,
    // Converter status and result.
    output logic            start_o,
    output logic            done_n_o,
    output logic [7:0]      result_o
);

    adhp_pkg::adhp_conv_state_t st_r;
    adhp_pkg::adhp_conv_state_t st_nxt;

    // Offset binary is the two's complement code with its sign bit inverted.
    function automatic logic [7:0] code_result(input logic offset, input logic [7:0] raw);
        code_result = offset ? {~raw[7], raw[6:0]} : raw;
    endfunction

    // ==================================================================
    // Sequencer.
    always_comb begin
        st_nxt       = st_r;
        st_nxt.start = start_req_i;
        if (st_r.start) begin
            st_nxt.done_n   = 1'b0;
            st_nxt.running  = 1'b1;
            st_nxt.edge_cnt = 4'h0;
        end else if (st_r.running) begin
            st_nxt.edge_cnt = st_r.edge_cnt + 4'h1;
            if (st_r.edge_cnt == adhp_pkg::ADHP_CONV_END_EDGES - 4'h1) begin
                st_nxt.done_n  = 1'b1;
                st_nxt.running = 1'b0;
                st_nxt.result  = code_result(offset_binary_i, sample_i);
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_r <= '{start: 1'b0, running: 1'b0, done_n: 1'b1, edge_cnt: 4'h0,
                      result: adhp_pkg::ADHP_RESULT_RESET};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign start_o  = st_r.start;
    assign done_n_o = st_r.done_n;
    assign result_o = st_r.result;

endmodule // adhp_conv_core

// ---- rtl/adhp_host_port.sv ----
// Host I/O port logic for the eight-channel converter and output latch card.
// Operation
// - four consecutive ports decoded at base; alternate jumper, with default jumper clear, moves base up four.
// - write to channel port latches channel number zero to seven.
// - channel holds across conversions until a new channel write.
// - reset selects input channel zero.
// - any write to conversion port starts one conversion; data ignored.
// - read of conversion port returns latest eight-bit result.
// - write to output port latches value for the output converter.
// - write to interrupt port asserts slot interrupt line.
// - read of interrupt port deasserts slot interrupt line.
// - status bit zero reads zero while converting, one when complete.
// - completion asserts one of three interrupt lines, or none, per routing.
// - format setting picks offset binary or two's complement result.
// - done low first edge after start high, high eighth edge after.
`timescale 1ns/10ps

module adhp_host_port (
    // Clock and reset.
    input  wire logic                    clk_sys_i,
    input  wire logic                    reset_n_i,
    // Option-slot I/O bus, strobes active low.
    input  wire logic [7:0]              addr_i,
    input  wire logic                    io_rd_n_i,
    input  wire logic                    io_wr_n_i,
    input  wire logic [7:0]              data_i,
    output logic [7:0]                   data_o,
    output logic                         data_oe_n_o,
    // Card jumpers.
    input  wire adhp_pkg::adhp_jumpers_t jumpers_i,
    // Analog front end.
    input  wire logic [7:0]              sample_i,
    output logic [2:0]                   adc_channel_o,
    output logic                         adc_start_o,
    output logic                         adc_done_n_o,
    // Output converter value.
    output logic [7:0]                   analog_output_value_o,
    // Interrupt lines.
    output adhp_pkg::adhp_irq_lines_t    irq_o
);

    adhp_pkg::adhp_port_state_t st_r;
    adhp_pkg::adhp_port_state_t st_nxt;

    logic [7:0] base;
    logic       hit;
    logic [1:0] idx;
    logic       rd_first;
    logic       wr_first;
    logic       start_req;
    logic       done_n;
    logic [7:0] result;
    logic       done_rise;
    logic [7:0] status_word;

    // ==================================================================
    // Address decode.
    // base select and decode
    assign base = (jumpers_i.alternate_base && !jumpers_i.default_base) ?
                  adhp_pkg::ADHP_OFS_CHANNEL_SELECT + adhp_pkg::ADHP_ALT_BASE_SHIFT :
                  adhp_pkg::ADHP_OFS_CHANNEL_SELECT;
    assign hit  = ((addr_i & adhp_pkg::ADHP_PORT_MASK) == base);
    assign idx  = addr_i[1:0];

    // Strobes act once, on their first low cycle.
    assign rd_first = !io_rd_n_i && st_r.rd_prev && hit;
    assign wr_first = !io_wr_n_i && st_r.wr_prev && hit;

    assign start_req = wr_first && (idx == adhp_pkg::ADHP_IDX_START_RESULT);

    // ==================================================================
    // Converter sequencer.
    adhp_conv_core adhp_conv_core_inst (
        .clk_sys_i       (clk_sys_i),
        .reset_n_i       (reset_n_i),
        .start_req_i     (start_req),
        .offset_binary_i (jumpers_i.result_format),
        .sample_i        (sample_i),
        .start_o         (adc_start_o),
        .done_n_o        (done_n),
        .result_o        (result)
    );

    assign done_rise = done_n && !st_r.done_n_prev;

    always_comb begin
        status_word = 8'h00;
        status_word[adhp_pkg::ADHP_STATUS_DONE_BIT] = !st_r.busy;
    end

    // ==================================================================
    // Port state.
    always_comb begin
        st_nxt             = st_r;
        st_nxt.rd_prev     = io_rd_n_i;
        st_nxt.wr_prev     = io_wr_n_i;
        st_nxt.done_n_prev = done_n;

        if (wr_first) begin
            case (idx)
                adhp_pkg::ADHP_IDX_CHANNEL: begin
                    st_nxt.channel = data_i[adhp_pkg::ADHP_CHANNEL_MSB:0];
                end
                adhp_pkg::ADHP_IDX_DAC: begin
                    st_nxt.dac_value = data_i;
                end
                default: begin
                end
            endcase
        end

        if (done_rise) begin
            st_nxt.busy = 1'b0;
        end
        if (start_req) begin
            st_nxt.busy = 1'b1;
        end

        if (rd_first && idx == adhp_pkg::ADHP_IDX_IRQ_STATUS) begin
            st_nxt.host_irq = 1'b0;
        end
        if (wr_first && idx == adhp_pkg::ADHP_IDX_IRQ_STATUS) begin
            st_nxt.host_irq = 1'b1;
        end

        if (start_req) begin
            st_nxt.cmp_irq = 1'b0;
        end else if (rd_first && idx == adhp_pkg::ADHP_IDX_IRQ_STATUS && jumpers_i.route_slot) begin
            st_nxt.cmp_irq = 1'b0;
        end
        if (done_rise) begin
            st_nxt.cmp_irq = 1'b1;
        end

        case (idx)
            adhp_pkg::ADHP_IDX_START_RESULT: st_nxt.rd_data = result;
            adhp_pkg::ADHP_IDX_IRQ_STATUS:   st_nxt.rd_data = status_word;
            default:                         st_nxt.rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_r <= '{channel: adhp_pkg::ADHP_CHANNEL_RESET, dac_value: adhp_pkg::ADHP_DAC_RESET,
                      rd_data: 8'h00, rd_prev: 1'b1, wr_prev: 1'b1, busy: 1'b0,
                      done_n_prev: 1'b1, host_irq: 1'b0, cmp_irq: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==================================================================
    // Outputs.
    // write-only ports undriven
    assign data_oe_n_o = !(!io_rd_n_i && hit &&
                           (idx == adhp_pkg::ADHP_IDX_START_RESULT || idx == adhp_pkg::ADHP_IDX_IRQ_STATUS));
    assign data_o      = st_r.rd_data;

    assign adc_channel_o         = st_r.channel;
    assign adc_done_n_o          = done_n;
    assign analog_output_value_o = st_r.dac_value;

    assign irq_o = '{slot: st_r.host_irq || (st_r.cmp_irq && jumpers_i.route_slot),
                     one:  st_r.cmp_irq && jumpers_i.route_one && !jumpers_i.route_slot,
                     two:  st_r.cmp_irq && jumpers_i.route_two && !jumpers_i.route_slot && !jumpers_i.route_one};

endmodule // adhp_host_port

// ---- dv/adhp_host_port_asserts.sv ----
// Concurrent checks on the converter host port, bound to its ports.
`timescale 1ns/10ps

module adhp_host_port_asserts (
    input wire logic                    clk_sys_i,
    input wire logic                    reset_n_i,
    input wire logic [7:0]              addr_i,
    input wire logic                    io_rd_n_i,
    input wire logic                    io_wr_n_i,
    input wire logic [7:0]              data_i,
    input wire logic                    data_oe_n_o,
    input wire adhp_pkg::adhp_jumpers_t jumpers_i,
    input wire logic [2:0]              adc_channel_o,
    input wire logic                    adc_start_o,
    input wire logic                    adc_done_n_o,
    input wire logic [7:0]              analog_output_value_o,
    input wire adhp_pkg::adhp_irq_lines_t irq_o
);
    // ==================================================================
    // Strobe edge detection and port decode.
    logic       rd_q_r;
    logic       wr_q_r;
    logic [7:0] base;
    logic [1:0] idx;
    logic [2:0] chan_d;
    logic       hit;
    logic       wr_t;
    logic       rd_t;
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_q_r <= 1'b1;
            wr_q_r <= 1'b1;
        end else begin
            rd_q_r <= io_rd_n_i;
            wr_q_r <= io_wr_n_i;
        end
    end
    assign base   = (jumpers_i.alternate_base && !jumpers_i.default_base) ?
                    adhp_pkg::ADHP_OFS_CHANNEL_SELECT + adhp_pkg::ADHP_ALT_BASE_SHIFT :
                    adhp_pkg::ADHP_OFS_CHANNEL_SELECT;
    assign hit    = (addr_i & adhp_pkg::ADHP_PORT_MASK) == base;
    assign idx    = addr_i[1:0];
    assign chan_d = data_i[2:0];
    assign wr_t   = hit && !io_wr_n_i && wr_q_r;
    assign rd_t   = hit && !io_rd_n_i && rd_q_r;

    // ==================================================================
    // Properties.
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    start_pulse_a: assert property (wr_t && idx == adhp_pkg::ADHP_IDX_START_RESULT |=>
        adc_start_o ##1 !adc_start_o) else $error("start pulse missing");
    done_low_a: assert property (adc_start_o |=> !adc_done_n_o) else $error("done not low");
    done_high_a: assert property ($fell(adc_start_o) |->
        !adc_done_n_o [*8] ##1 adc_done_n_o) else $error("done high at wrong edge");
    chan_latch_a: assert property (wr_t && idx == adhp_pkg::ADHP_IDX_CHANNEL |=>
        adc_channel_o == $past(chan_d)) else $error("channel not latched");
    chan_hold_a: assert property (!(wr_t && idx == adhp_pkg::ADHP_IDX_CHANNEL) |=>
        $stable(adc_channel_o)) else $error("channel changed");
    dac_latch_a: assert property (wr_t && idx == adhp_pkg::ADHP_IDX_DAC |=>
        analog_output_value_o == $past(data_i)) else $error("output value not latched");
    slot_set_a: assert property (wr_t && idx == adhp_pkg::ADHP_IDX_IRQ_STATUS |=>
        irq_o.slot) else $error("slot line not raised");
    slot_clear_a: assert property (rd_t && idx == adhp_pkg::ADHP_IDX_IRQ_STATUS && io_wr_n_i
        && $stable(adc_done_n_o) |=> !irq_o.slot) else $error("slot line not cleared");
    oe_drive_a: assert property (data_oe_n_o == !(!io_rd_n_i && hit && idx[0]))
        else $error("read drive wrong");
    route_irq_a: assert property ($rose(adc_done_n_o) |=>
        irq_o.one == (jumpers_i.route_one && !jumpers_i.route_slot) && irq_o.two ==
        (jumpers_i.route_two && !jumpers_i.route_one && !jumpers_i.route_slot))
        else $error("completion routing wrong");
endmodule // adhp_host_port_asserts

bind adhp_host_port adhp_host_port_asserts adhp_host_port_asserts_inst (.clk_sys_i, .reset_n_i,
    .addr_i, .io_rd_n_i, .io_wr_n_i, .data_i, .data_oe_n_o, .jumpers_i, .adc_channel_o,
    .adc_start_o, .adc_done_n_o, .analog_output_value_o, .irq_o);

// ---- dv/adhp_host_model.sv ----
// Host processor model that makes I/O read and write cycles on the option slot.
`timescale 1ns/10ps

module adhp_host_model (
    // Clock.
    input  wire logic [0:0] clk_sys_i,
    // Option-slot bus.
    input  wire logic [7:0] rd_data_i,
    output logic [7:0]      addr_o,
    output logic            rd_n_o,
    output logic            wr_n_o,
    output logic [7:0]      wr_data_o
);
    initial begin
        addr_o    = 8'h00;
        rd_n_o    = 1'b1;
        wr_n_o    = 1'b1;
        wr_data_o = 8'h00;
    end
    // Released lines show the inverse so stale values cannot pass.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        #1;
        addr_o    = a;
        wr_data_o = d;
        wr_n_o    = 1'b0;
        @(posedge clk_sys_i);
        #1;
        wr_n_o    = 1'b1;
        addr_o    = ~a;
        wr_data_o = ~d;
    endtask
    // only result and status ports are read.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        #1;
        addr_o = a;
        rd_n_o = 1'b0;
        repeat (2) @(posedge clk_sys_i);
        #1;
        d      = rd_data_i;
        rd_n_o = 1'b1;
        addr_o = ~a;
    endtask
endmodule // adhp_host_model

// ---- dv/adhp_host_port_tb.sv ----
// Self-checking bench for the converter host port.
`timescale 1ns/10ps

module adhp_host_port_tb;
    logic                      clk_sys_i;
    logic                      reset_n_i;
    logic [7:0]                addr_i;
    logic                      io_rd_n_i;
    logic                      io_wr_n_i;
    logic [7:0]                data_i;
    logic [7:0]                data_o;
    logic                      data_oe_n_o;
    adhp_pkg::adhp_jumpers_t   jumpers_i;
    logic [7:0]                sample_i;
    logic [2:0]                adc_channel_o;
    logic                      adc_start_o;
    logic                      adc_done_n_o;
    logic [7:0]                analog_output_value_o;
    adhp_pkg::adhp_irq_lines_t irq_o;
    logic [7:0]                base;
    logic [7:0]                rv;
    logic [7:0]                s;
    int                        n_errors;
    int                        n_checks;

    adhp_host_port adhp_host_port_inst (.clk_sys_i, .reset_n_i, .addr_i, .io_rd_n_i, .io_wr_n_i,
        .data_i, .data_o, .data_oe_n_o, .jumpers_i, .sample_i, .adc_channel_o, .adc_start_o,
        .adc_done_n_o, .analog_output_value_o, .irq_o);
    adhp_host_model host (.clk_sys_i(clk_sys_i), .rd_data_i(data_o), .addr_o(addr_i),
        .rd_n_o(io_rd_n_i), .wr_n_o(io_wr_n_i), .wr_data_o(data_i));

    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic test_done;
        if (n_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // One conversion with its status, routing and result checks.
    task automatic conv(input logic [7:0] smp, input logic [7:0] res, input logic [2:0] q);
        int k;
        k = 0;
        sample_i = smp;
        repeat (500) @(posedge clk_sys_i);
        host.wr(base + 8'h01, 8'h5A);
        @(posedge clk_sys_i);
        #1;
        chk({5'h00, irq_o}, 8'h00);
        host.rd(base + 8'h03, rv);
        chk(rv & 8'h01, 8'h00);
        while (adc_done_n_o !== 1'b1 && k < 50) begin
            @(posedge clk_sys_i);
            #1;
            k++;
        end
        if (k == 50) begin
            n_errors++;
            test_done();
        end
        @(posedge clk_sys_i);
        #1;
        chk({5'h00, irq_o}, {5'h00, q});
        host.rd(base + 8'h03, rv);
        chk(rv & 8'h01, 8'h01);
        host.rd(base + 8'h01, rv);
        chk(rv, res);
    endtask

    initial begin
        n_errors  = 0;
        n_checks  = 0;
        reset_n_i = 1'b0;
        sample_i  = 8'h00;
        base      = 8'hA0;
        jumpers_i = '0;
        jumpers_i.default_base = 1'b1;
        repeat (6) @(posedge clk_sys_i);
        #1;
        reset_n_i = 1'b1;
        chk({5'h00, adc_channel_o}, 8'h00);
        chk(analog_output_value_o, adhp_pkg::ADHP_DAC_RESET);
        chk({5'h00, irq_o}, 8'h00);
        host.rd(base + 8'h03, rv);
        chk(rv & 8'h01, 8'h01);
        host.wr(base, 8'hFD);
        chk({5'h00, adc_channel_o}, 8'h05);
        host.wr(base + 8'h02, 8'hA5);
        chk(analog_output_value_o, 8'hA5);
        host.wr(base + 8'h03, 8'h00);
        chk({7'h00, irq_o.slot}, 8'h01);
        host.rd(base + 8'h03, rv);
        chk({7'h00, irq_o.slot}, 8'h00);
        // Each routing setting with a boundary sample, alternating between the two result codings.
        for (int r = 0; r < 4; r++) begin
            jumpers_i.route_slot    = (r == 1);
            jumpers_i.route_one     = (r == 2);
            jumpers_i.route_two     = (r == 3);
            jumpers_i.result_format = r[0];
            s = r[0] ? (r[1] ? 8'h7F : 8'h80) : (r[1] ? 8'h00 : 8'hFF);
            repeat (2) conv(s, s ^ {r[0], 7'h00}, (r == 0) ? 3'h0 : 3'h4 >> (r - 1));
        end
        chk({5'h00, adc_channel_o}, 8'h05);
        jumpers_i.default_base   = 1'b0;
        jumpers_i.alternate_base = 1'b1;
        host.wr(base + 8'h02, 8'h77);
        chk(analog_output_value_o, 8'hA5);
        base = 8'hA4;
        host.wr(base + 8'h02, 8'h3C);
        chk(analog_output_value_o, 8'h3C);
        test_done();
    end
endmodule // adhp_host_port_tb
